//--- src/param_codec_consts.svh
// Constants for the four-word parameter channel codec
`ifndef PARAM_CODEC_CONSTS_SVH
`define PARAM_CODEC_CONSTS_SVH
`define CH_WORDS 4
`define HDR_CODE_HI 15
`define HDR_CODE_LO 12
`define HDR_NUM_HI 10
`define IDX_PAGE_HI 15
`define IDX_PAGE_LO 8
`define IDX_SUB_HI 7
`define VAL_DOBJ_LO 10
`define VAL_CSEL_HI 9
`define RED_NUM_MAX 11'h7cf
`define RED_NUM_MIN_P70 11'h3e8
`define PAGE_0 8'h00
`define PAGE_2K 8'h80
`define PAGE_6K 8'h90
`define PAGE_8K 8'h20
`define PAGE_10K 8'ha0
`define PAGE_20K 8'h50
`define PAGE_28K 8'h70
`define PAGE_30K 8'hf0
`define PAGE_60K 8'h74
`define OFS_0 16'h0000
`define OFS_2K 16'h07d0
`define OFS_6K 16'h1770
`define OFS_8K 16'h1f40
`define OFS_10K 16'h2710
`define OFS_20K 16'h4e20
`define OFS_28K 16'h6d60
`define OFS_30K 16'h7530
`define OFS_60K 16'hea60
`define REQ_READ_ALIAS 4'h1
`define REQ_WRITE_ALIAS 4'h2
`define REQ_READ_FIELD 4'h6
`define REQ_WRITE_WORD 4'h7
`define RSP_CANNOT 4'h7
`define ERR_NO_PARAM 16'h0000
`endif

//--- src/param_codec_pkg.sv
// Types shared by the parameter channel codec
`default_nettype none
package param_codec_pkg;
	typedef enum logic [1:0] {VK_8, VK_16, VK_32, VK_CONN} value_kind_e;
	// One decoded request
	typedef struct packed {
		logic [3:0] code;
		logic isRead;
		logic isWrite;
		logic [10:0] reducedNum;
		logic [7:0] pageIdx;
		logic [15:0] fullNum;
		logic [7:0] subIdx;
		logic [15:0] valHigh;
		logic [15:0] valLow;
		logic [5:0] driveObj;
		logic [9:0] connSel;
	} req_s;
	// One answer from the parameter store
	typedef struct packed {
		logic [3:0] code;
		logic exists;
		value_kind_e kind;
		logic [31:0] data;
	} rsp_s;
endpackage
`default_nettype wire

//--- src/param_channel_codec.sv
// Decoder and encoder for the four-word parameter channel
//
// Function
// - Page codes 0,80,90,20,A0,50,70,F0,74 hex select offsets 0 to 60000.
// - The drive rebuilds the full number as page offset plus reduced number.
// - The array index travels in index bits 7..0, zero for plain parameters.
// - Header bits 15..12 hold the request code and 6 means read an element.
// - Code 7 changes a word element with the page, subindex and value sent.
// - An 8-bit value sits in low word bits 7..0 with everything else zero.
// - A 16-bit value fills the low word and the high word is zero.
// - A 32-bit value puts bits 31..16 in the high word and 15..0 in the low.
// - A connector has its number in the high word, its object in low 15..10.
// - Low bits 9..0 of a connector carry its index or bit-field number.
// - The channel is header, index, high value, low value, in that order.
// - A missing parameter is answered with cannot-process and error zero.
`include "param_codec_consts.svh"
`default_nettype none
module param_channel_codec
	import param_codec_pkg::*;
(
	input wire logic clk, // 125 MHz system clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [15:0] wordIn, // Incoming channel word
	input wire logic wordInValid, // Word present this cycle
	output logic wordInReady, // Codec accepts words
	output logic reqValid, // One-cycle pulse with decoded request
	output req_s req, // Decoded request
	input wire logic rspValid, // Store answer present
	input wire rsp_s rsp, // Store answer
	output logic rspReady, // Codec waits for an answer
	output logic [15:0] wordOut, // Outgoing channel word
	output logic wordOutValid // Outgoing word present
);

	typedef enum logic [1:0] {ST_RECV, ST_WAIT, ST_SEND} state_e;

	// Page code to offset lookup, bit 16 marks a known code
	function automatic logic [16:0] pageOffset(input logic [7:0] page);
		case (page)
			`PAGE_0: pageOffset = {1'b1, `OFS_0};
			`PAGE_2K: pageOffset = {1'b1, `OFS_2K};
			`PAGE_6K: pageOffset = {1'b1, `OFS_6K};
			`PAGE_8K: pageOffset = {1'b1, `OFS_8K};
			`PAGE_10K: pageOffset = {1'b1, `OFS_10K};
			`PAGE_20K: pageOffset = {1'b1, `OFS_20K};
			`PAGE_28K: pageOffset = {1'b1, `OFS_28K};
			`PAGE_30K: pageOffset = {1'b1, `OFS_30K};
			`PAGE_60K: pageOffset = {1'b1, `OFS_60K};
			default: pageOffset = 17'h00000;
		endcase
	endfunction

	// Value justification for an answer
	function automatic logic [31:0] justify(input value_kind_e k,
		input logic [31:0] d);
		case (k)
			VK_8: justify = {24'h000000, d[7:0]};
			VK_16: justify = {16'h0000, d[15:0]};
			VK_32: justify = d;
			VK_CONN: justify = d;
			default: justify = 32'h00000000;
		endcase
	endfunction

	state_e state_q, state_d;
	logic [1:0] cnt_q;
	logic [15:0] rx_q [0:2];
	logic [15:0] frame_q [0:3];
	logic reqValid_q;
	req_s req_q;
	logic [15:0] wordOut_q;
	logic wordOutValid_q;
	logic inReady_q;
	logic rspReady_q;

	// Fields of the frame in flight; the fourth word is taken live
	// A word counts only while ready shows, so none slips in after reset
	wire logic takeIn = (state_q == ST_RECV) && inReady_q && wordInValid;
	wire logic lastIn = takeIn && (cnt_q == 2'(`CH_WORDS - 1));
	wire logic [15:0] hdrWord = rx_q[0];
	wire logic [15:0] idxWord = rx_q[1];
	wire logic [3:0] rawCode = hdrWord[`HDR_CODE_HI:`HDR_CODE_LO];
	wire logic [10:0] redNum = hdrWord[`HDR_NUM_HI:0];
	wire logic [7:0] page = idxWord[`IDX_PAGE_HI:`IDX_PAGE_LO];
	wire logic [7:0] subIdx = idxWord[`IDX_SUB_HI:0];
	wire logic [16:0] ofs = pageOffset(page);
	wire logic [15:0] fullNum = ofs[15:0] + 16'(redNum);
	// Page 70 hex only covers the upper half of its window
	wire logic numOk = ofs[16] && (redNum <= `RED_NUM_MAX) &&
		(page != `PAGE_28K || redNum >= `RED_NUM_MIN_P70);
	// Old aliases 1 and 2 are folded onto 6 and 7
	wire logic isRead = (rawCode == `REQ_READ_FIELD) ||
		(rawCode == `REQ_READ_ALIAS);
	wire logic isWrite = (rawCode == `REQ_WRITE_WORD) ||
		(rawCode == `REQ_WRITE_ALIAS);
	// Value words of a read are dropped, whatever the master sent
	wire logic [15:0] valHi = isRead ? 16'h0000 : rx_q[2];
	wire logic [15:0] valLo = isRead ? 16'h0000 : wordIn;
	wire logic rspTake = (state_q == ST_WAIT) && rspValid;
	wire logic [31:0] rspVal = justify(rsp.kind, rsp.data);
	wire logic lastOut = (state_q == ST_SEND) &&
		(cnt_q == 2'(`CH_WORDS - 1));

	// Sequencing: receive four, wait for the store if the number is known, send four
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RECV: begin
				if (lastIn) begin
					state_d = numOk ? ST_WAIT : ST_SEND;
				end
			end
			ST_WAIT: begin
				if (rspValid) begin
					state_d = ST_SEND;
				end
			end
			ST_SEND: begin
				if (lastOut) begin
					state_d = ST_RECV;
				end
			end
			default: state_d = ST_RECV;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_RECV;
			inReady_q <= 1'b0;
			rspReady_q <= 1'b0;
		end else begin
			state_q <= state_d;
			inReady_q <= (state_d == ST_RECV);
			rspReady_q <= (state_d == ST_WAIT);
		end
	end

	// Word counter, shared by receive and send
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 2'd0;
		end else if (state_d != state_q) begin
			cnt_q <= 2'd0;
		end else if (takeIn || state_q == ST_SEND) begin
			cnt_q <= cnt_q + 2'd1;
		end
	end

	// First three words are held until the fourth arrives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				rx_q[i] <= 16'h0000;
			end
		end else if (takeIn && !lastIn) begin
			rx_q[cnt_q] <= wordIn;
		end
	end

	// Decoded request goes out as a single pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reqValid_q <= 1'b0;
			req_q <= '0;
		end else begin
			reqValid_q <= lastIn && numOk;
			if (lastIn) begin
				req_q <= '{code: rawCode, isRead: isRead,
					isWrite: isWrite, reducedNum: redNum, pageIdx: page,
					fullNum: fullNum, subIdx: subIdx, valHigh: valHi,
					valLow: valLo,
					driveObj: valLo[15:`VAL_DOBJ_LO],
					connSel: valLo[`VAL_CSEL_HI:0]};
			end
		end
	end

	// Answer frame echoes number, page and subindex of the request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `CH_WORDS; i++) begin
				frame_q[i] <= 16'h0000;
			end
		end else if (lastIn && !numOk) begin
			frame_q[0] <= {`RSP_CANNOT, 1'b0, redNum};
			frame_q[1] <= idxWord;
			frame_q[2] <= `ERR_NO_PARAM;
			frame_q[3] <= `ERR_NO_PARAM;
		end else if (rspTake) begin
			frame_q[0] <= {(rsp.exists ? rsp.code : `RSP_CANNOT), 1'b0,
				req_q.reducedNum};
			frame_q[1] <= {req_q.pageIdx, req_q.subIdx};
			frame_q[2] <= rsp.exists ? rspVal[31:16] : `ERR_NO_PARAM;
			frame_q[3] <= rsp.exists ? rspVal[15:0] : `ERR_NO_PARAM;
		end
	end

	// Serial output, header first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wordOut_q <= 16'h0000;
			wordOutValid_q <= 1'b0;
		end else begin
			wordOutValid_q <= (state_q == ST_SEND);
			wordOut_q <= (state_q == ST_SEND) ? frame_q[cnt_q] : 16'h0000;
		end
	end

	assign wordInReady = inReady_q;
	assign rspReady = rspReady_q;
	assign reqValid = reqValid_q;
	assign req = req_q;
	assign wordOut = wordOut_q;
	assign wordOutValid = wordOutValid_q;

	// Checks; the offset of the held request is looked up apart
	wire logic [16:0] reqOfs = pageOffset(req.pageIdx);
	property p_numRebuild;
		@(posedge clk) disable iff (!rst_n)
		reqValid |-> req.fullNum == reqOfs[15:0] + 16'(req.reducedNum);
	endproperty
	a_numRebuild: assert property (p_numRebuild)
		else $error("full number not page offset plus reduced number");

	property p_readCode;
		@(posedge clk) disable iff (!rst_n)
		reqValid && req.code == `REQ_READ_FIELD |-> req.isRead && !req.isWrite;
	endproperty
	a_readCode: assert property (p_readCode)
		else $error("code 6 not decoded as read");

	property p_writeCode;
		@(posedge clk) disable iff (!rst_n)
		reqValid && req.code == `REQ_WRITE_WORD |-> req.isWrite &&
			req.valLow == $past(wordIn) && req.subIdx == $past(rx_q[1][7:0]);
	endproperty
	a_writeCode: assert property (p_writeCode)
		else $error("code 7 write fields wrong");

	property p_readIgnore;
		@(posedge clk) disable iff (!rst_n)
		reqValid && req.isRead |-> req.valHigh == 16'h0000 &&
			req.valLow == 16'h0000;
	endproperty
	a_readIgnore: assert property (p_readIgnore)
		else $error("read request carried value words");

	property p_fourWords;
		@(posedge clk) disable iff (!rst_n)
		$rose(wordOutValid) |-> wordOutValid [*4] ##1 !wordOutValid;
	endproperty
	a_fourWords: assert property (p_fourWords)
		else $error("answer is not four words long");

	property p_missing;
		@(posedge clk) disable iff (!rst_n)
		lastIn && !numOk |-> ##2 wordOutValid &&
			wordOut[15:12] == `RSP_CANNOT ##2 wordOut == 16'h0000
			##1 wordOut == 16'h0000;
	endproperty
	a_missing: assert property (p_missing)
		else $error("missing parameter not answered with error zero");

	property p_just8;
		@(posedge clk) disable iff (!rst_n)
		rspTake && rsp.exists && rsp.kind == VK_8 |=>
			frame_q[2] == 16'h0000 && frame_q[3][15:8] == 8'h00 &&
			frame_q[3][7:0] == $past(rsp.data[7:0]);
	endproperty
	a_just8: assert property (p_just8)
		else $error("8-bit answer not right-justified");

	property p_just16;
		@(posedge clk) disable iff (!rst_n)
		rspTake && rsp.exists && rsp.kind == VK_16 |=>
			frame_q[2] == 16'h0000 && frame_q[3] == $past(rsp.data[15:0]);
	endproperty
	a_just16: assert property (p_just16)
		else $error("16-bit answer misplaced");

	property p_just32;
		@(posedge clk) disable iff (!rst_n)
		rspTake && rsp.exists && rsp.kind inside {VK_32, VK_CONN} |=>
			{frame_q[2], frame_q[3]} == $past(rsp.data);
	endproperty
	a_just32: assert property (p_just32)
		else $error("32-bit or connector answer misplaced");

	property p_connDecode;
		@(posedge clk) disable iff (!rst_n)
		reqValid && !req.isRead |->
			req.driveObj == $past(wordIn[15:`VAL_DOBJ_LO]) &&
			req.connSel == $past(wordIn[`VAL_CSEL_HI:0]);
	endproperty
	a_connDecode: assert property (p_connDecode)
		else $error("connector fields not taken from low word");

	property p_echoIndex;
		@(posedge clk) disable iff (!rst_n)
		rspTake |-> ##3 wordOutValid &&
			wordOut == {req.pageIdx, req.subIdx};
	endproperty
	a_echoIndex: assert property (p_echoIndex)
		else $error("answer index word differs from request");

endmodule // param_channel_codec
`default_nettype wire

//--- tb/master_model.sv
// Fieldbus master model that sends one four-word request frame
`default_nettype none
module master_model (
	input wire logic clk, // System clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic go, // Start a frame
	input wire logic [63:0] frame, // Header, index, high, low words
	input wire logic wordInReady, // Codec accepts words
	output logic [15:0] wordIn, // Channel word
	output logic wordInValid, // Word present
	output logic busy // Frame in flight
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] left;
	logic [47:0] rest;
	assign busy = left != 3'h0;
	// Word held until taken; idle line toggles so stale data never passes
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left <= 3'h0;
			wordInValid <= 1'b0;
			wordIn <= 16'h0000;
		end else if (left == 3'h0 && go) begin
			wordIn <= frame[63:48];
			rest <= frame[47:0];
			wordInValid <= 1'b1;
			left <= 3'h4;
		end else if (wordInValid && wordInReady) begin
			left <= left - 3'h1;
			rest <= {rest[31:0], 16'h0000};
			wordIn <= (left == 3'h1) ? ~wordIn : rest[47:32];
			wordInValid <= left != 3'h1;
		end else if (!wordInValid) begin
			wordIn <= ~wordIn;
		end
	end
endmodule // master_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the parameter channel codec
`default_nettype none
module tb
	import param_codec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, go, busy, wordInValid, wordInReady, reqValid;
	logic rspValid, rspReady, wordOutValid;
	logic [63:0] frame;
	logic [15:0] wordIn, wordOut;
	req_s req;
	rsp_s rsp;
	int numErrors = 0;
	int checksDone = 0;
	integer seed = 32'hdb20;
	int ofs[9] = '{0, 2000, 6000, 8000, 10000, 20000, 28000, 30000, 60000};
	logic [7:0] pg[9] = '{8'h00, 8'h80, 8'h90, 8'h20, 8'ha0, 8'h50,
		8'h70, 8'hf0, 8'h74};
	logic [3:0] codes[4] = '{4'h6, 4'h7, 4'h1, 4'h2};
	logic [15:0] expQ[$];

	master_model mst (.clk(clk), .rst_n(rst_n), .go(go), .frame(frame),
		.wordInReady(wordInReady), .wordIn(wordIn),
		.wordInValid(wordInValid), .busy(busy));
	param_channel_codec uut (.clk(clk), .rst_n(rst_n), .wordIn(wordIn),
		.wordInValid(wordInValid), .wordInReady(wordInReady),
		.reqValid(reqValid), .req(req), .rspValid(rspValid), .rsp(rsp),
		.rspReady(rspReady), .wordOut(wordOut),
		.wordOutValid(wordOutValid));

	// Free-running 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			numErrors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task finishTest;
		if (numErrors == 0 && checksDone > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Bounded wait at falling edges; a request pulse is refused on bad frames
	task waitSig(input bit onOut);
		int n;
		n = 0;
		while ((onOut ? wordOutValid : reqValid) !== 1'b1) begin
			if (onOut) chk("reqValid", reqValid, 0);
			@(negedge clk);
			n++;
			if (n > 60) begin
				numErrors++;
				finishTest();
			end
		end
	endtask

	// One request and its answer, checked against the model
	task frameRun(input int p, input int num, input logic [3:0] code,
		input logic [7:0] sub, input logic [31:0] val,
		input logic [3:0] rc, input bit ex, input value_kind_e k);
		logic [7:0] page;
		logic [15:0] hi, lo;
		logic [31:0] sent;
		bit good, rd, ok;
		page = (p < 9) ? pg[p] : 8'h33; // 33h is no page code
		good = p < 9 && num < 2000 && !(p == 6 && num < 1000);
		rd = code == 4'h6 || code == 4'h1;
		hi = rd ? 16'h0000 : val[31:16];
		lo = rd ? 16'h0000 : val[15:0];
		// Reads with an odd subindex carry junk to show it is ignored
		sent = (rd && !sub[0]) ? 32'h00000000 : val;
		ok = good && ex;
		expQ.push_back({ok ? rc : 4'h7, 1'b0, num[10:0]});
		expQ.push_back({page, sub});
		expQ.push_back((!ok || k < VK_32) ? 16'h0000 : val[31:16]);
		expQ.push_back(!ok ? 16'h0000 : k == VK_8 ? {8'h00, val[7:0]} :
			val[15:0]);
		@(posedge clk);
		frame <= {code, 1'b0, num[10:0], page, sub, sent};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(negedge clk);
		if (good) begin
			waitSig(0);
			chk("fullNum", req.fullNum, ofs[p] + num);
			chk("reducedNum", req.reducedNum, num[10:0]);
			chk("pageIdx", req.pageIdx, page);
			chk("subIdx", req.subIdx, sub);
			chk("code", req.code, code);
			chk("isRead", req.isRead, rd);
			chk("isWrite", req.isWrite, code == 4'h7 || code == 4'h2);
			chk("valHigh", req.valHigh, hi);
			chk("valLow", req.valLow, lo);
			chk("driveObj", req.driveObj, lo[15:10]);
			chk("connSel", req.connSel, lo[9:0]);
			chk("rspReady", rspReady, 1);
			@(posedge clk);
			rspValid <= 1'b1;
			rsp <= '{rc, ex, k, val};
			@(posedge clk);
			rspValid <= 1'b0;
			@(negedge clk);
		end
		waitSig(1);
		for (int w = 0; w < 4; w++) begin
			chk("wordOutValid", wordOutValid, 1);
			chk("wordOut", wordOut, expQ.pop_front());
			@(negedge clk);
		end
		chk("wordOutValid", wordOutValid, 0);
		chk("wordInReady", wordInReady, 1);
	endtask

	// Reset, then every page code against each number class
	initial begin
		int num;
		rst_n = 1'b0;
		go = 1'b0;
		frame = 64'h0;
		rspValid = 1'b0;
		rsp = '0;
		repeat (16) @(posedge clk);
		chk("reqValid", reqValid, 0);
		chk("wordOutValid", wordOutValid, 0);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 40; i++) begin
			case (i / 10)
				0: num = 1999;
				1: num = $unsigned($random(seed)) % 1000;
				2: num = 2000 + $unsigned($random(seed)) % 48;
				default: num = $unsigned($random(seed)) % 2000;
			endcase
			frameRun(i % 10, num, codes[$unsigned($random(seed)) % 4],
				8'($random(seed)), 32'($random(seed)), 4'($random(seed)),
				(i % 5) != 4, value_kind_e'(i % 4));
		end
		finishTest();
	end
endmodule // tb
`default_nettype wire
